// file: rtl/mcl_pkg.sv
// constants, types and decode helpers for the multiplex command/monitor link
package mcl_pkg;

  // widths of the multiplex address, words and line groups
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;
  localparam int SUB_W = 4;
  localparam int SET_W = 3;
  localparam int CMD_SETS = 3;
  localparam int MON_SETS = 4;
  localparam int ANA_CTRLS = 8;

  // upper-nibble group bases; each decode state spans 16 addresses
  localparam logic [3:0] ANA_GRP_BASE = 4'h0;
  localparam logic [3:0] MON_GRP_BASE = 4'h8;
  localparam logic [3:0] CMD_GRP_BASE = 4'hC;

  // monitor shift: a pause slot after every eight data slots
  localparam int PAUSE_EVERY = 9;
  localparam int MON_SLOTS = 27;

  // timing, in nanoseconds as specified, and derived link clock counts
  localparam int LINK_PERIOD_NS = 15;
  localparam int CLK_LOW_NS = 4000;
  localparam int CLK_HIGH_NS = 6000;
  localparam int CMD_STB_NS = 5000;
  localparam int MON_STB_NS = 10000;
  localparam int ANA_HOLD_NS = 100000;
  localparam int CLK_LOW_CYC = (CLK_LOW_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int CLK_HIGH_CYC = (CLK_HIGH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int CMD_STB_CYC = (CMD_STB_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int MON_STB_CYC = (MON_STB_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int ANA_HOLD_CYC = (ANA_HOLD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // result buffer depth
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {OP_NONE, OP_CMD, OP_MON, OP_ANA} mcl_op_e;

  // link sequencer states, gray coded in the order listed from idle to done; command strobe to done changes two bits
  typedef enum logic [2:0] {
    LS_IDLE = 3'h0,
    LS_SETUP = 3'h1,
    LS_CMD_SHIFT = 3'h3,
    LS_CMD_STROBE = 3'h2,
    LS_MON_STROBE = 3'h6,
    LS_MON_SHIFT = 3'h7,
    LS_ANA_HOLD = 3'h5,
    LS_DONE = 3'h4
  } mcl_lstate_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mcl_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] word;
  } mcl_mon_s;

  // upper nibble to operation kind
  function automatic mcl_op_e mcl_decode_op(input logic [ADDR_W-1:0] a);
    mcl_op_e op;
    op = OP_NONE;
    if (a[7:4] < MON_GRP_BASE)
      op = OP_ANA;
    else if (a[7:4] < CMD_GRP_BASE)
      op = OP_MON;
    else if (a[7:4] < CMD_GRP_BASE + 4'h3)
      op = OP_CMD;
    return op;
  endfunction

  // upper nibble to line set index within its kind
  function automatic logic [SET_W-1:0] mcl_decode_set(input logic [ADDR_W-1:0] a);
    logic [3:0] d;
    d = a[7:4] - ANA_GRP_BASE;
    if (a[7:4] >= CMD_GRP_BASE)
      d = a[7:4] - CMD_GRP_BASE;
    else if (a[7:4] >= MON_GRP_BASE)
      d = a[7:4] - MON_GRP_BASE;
    return d[SET_W-1:0];
  endfunction

endpackage

// file: rtl/mcl_link.sv
// multiplex command/monitor link sequencer with its monitor result buffer
`timescale 1ns/100ps
`default_nettype none

// result buffer: flip-flop storage, depth must be a power of two
module mcl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = mcl_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire logic do_wr;
  wire logic do_rd;

  // full when pointers wrap apart by exactly one lap
  assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) ||
                    (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // pointer update
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage needs no reset, empty flag guards it
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

module mcl_link #(
  parameter int ANA_HOLD_CYC = mcl_pkg::ANA_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic req_valid,
  output logic req_ready,
  input wire mcl_pkg::mcl_req_s req,
  output logic done,
  output logic done_bad,
  output logic mon_valid,
  input wire logic mon_ready,
  output mcl_pkg::mcl_mon_s mon,
  output logic [mcl_pkg::SUB_W-1:0] sub_addr_n,
  output logic [mcl_pkg::CMD_SETS-1:0] command_serial_line_n,
  output logic [mcl_pkg::CMD_SETS-1:0] command_shift_clock_n,
  output logic [mcl_pkg::CMD_SETS-1:0] command_latch_strobe_n,
  output logic [mcl_pkg::MON_SETS-1:0] monitor_load_strobe_n,
  output logic [mcl_pkg::MON_SETS-1:0] monitor_shift_clock_n,
  input wire logic [mcl_pkg::MON_SETS-1:0] monitor_serial_line_n,
  output logic [mcl_pkg::ANA_CTRLS-1:0] analog_sel_n
);
  // ---- reference clock side ----
  mcl_pkg::mcl_req_s held;
  logic pend;
  logic req_tog;
  logic ack_s1;
  logic ack_s2;
  logic ack_s3;
  logic fifo_in_ready;
  wire logic accept;
  wire logic ack_ev;
  wire logic push;
  wire mcl_pkg::mcl_op_e held_op;
  // ---- link clock side ----
  mcl_pkg::mcl_lstate_e l_state;
  mcl_pkg::mcl_lstate_e next_state;
  mcl_pkg::mcl_op_e l_op;
  mcl_pkg::mcl_op_e next_op;
  logic [mcl_pkg::SET_W-1:0] l_set;
  logic [mcl_pkg::SET_W-1:0] next_set;
  logic [mcl_pkg::ADDR_W-1:0] l_addr;
  logic [mcl_pkg::ADDR_W-1:0] next_addr;
  logic [mcl_pkg::DATA_W-1:0] sh;
  logic [mcl_pkg::DATA_W-1:0] next_sh;
  logic [mcl_pkg::DATA_W-1:0] word;
  logic [mcl_pkg::DATA_W-1:0] next_word;
  logic [15:0] tmr;
  logic [15:0] next_tmr;
  logic [4:0] slot;
  logic [4:0] next_slot;
  logic [3:0] pc;
  logic [3:0] next_pc;
  logic low;
  logic next_low;
  logic l_ack;
  logic next_ack;
  logic lk_rst_s1;
  logic lk_rst_b;
  logic rq_s1;
  logic rq_s2;
  logic rq_s3;
  logic [mcl_pkg::MON_SETS-1:0] min_s1;
  logic [mcl_pkg::MON_SETS-1:0] min_s2;
  wire logic req_ev;
  wire logic tmr_end;
  wire logic pause;
  wire logic mon_bit;
  wire logic cmd_clk_on;
  wire logic mon_clk_on;
  wire logic cmd_stb_on;
  wire logic mon_stb_on;
  wire logic cmd_line_on;
  wire logic ana_on;

  // request handshake: one operation in flight, none while buffer full
  assign held_op = mcl_pkg::mcl_decode_op(held.addr);
  assign req_ready = !pend && fifo_in_ready;
  assign accept = req_valid && req_ready;
  assign ack_ev = ack_s2 ^ ack_s3;
  assign push = ack_ev && (held_op == mcl_pkg::OP_MON);

  // request toggles out, completion toggles back through two flops
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pend <= 1'b0;
      req_tog <= 1'b0;
      held <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      done <= 1'b0;
      done_bad <= 1'b0;
    end
    else
    begin
      ack_s1 <= l_ack;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      done <= ack_ev;
      done_bad <= ack_ev && (held_op == mcl_pkg::OP_NONE);
      if (accept)
      begin
        held <= req;
        req_tog <= ~req_tog;
        pend <= 1'b1;
      end
      else if (ack_ev)
        pend <= 1'b0;
    end
  end

  // word is stable in the link domain until the next request
  mcl_fifo #(
    .WIDTH(mcl_pkg::ADDR_W + mcl_pkg::DATA_W),
    .DEPTH(mcl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({held.addr, word}),
    .out_valid(mon_valid),
    .out_ready(mon_ready),
    .out_data(mon)
  );

  // link domain reset and input synchronisers, no reset needed here
  always_ff @(posedge link_clk)
  begin
    lk_rst_s1 <= rst_b;
    lk_rst_b <= lk_rst_s1;
    min_s1 <= monitor_serial_line_n;
    min_s2 <= min_s1;
  end

  // request toggle crossing into the link domain
  always_ff @(posedge link_clk)
  begin
    if (!lk_rst_b)
    begin
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      rq_s3 <= 1'b0;
    end
    else
    begin
      rq_s1 <= req_tog;
      rq_s2 <= rq_s1;
      rq_s3 <= rq_s2;
    end
  end

  assign req_ev = rq_s2 ^ rq_s3;
  assign tmr_end = tmr == 16'h0000;
  assign pause = pc == 4'(mcl_pkg::PAUSE_EVERY - 1);
  assign mon_bit = min_s2[l_set[1:0]];

  // sequencer next state
  always_comb
  begin
    next_state = l_state;
    next_op = l_op;
    next_set = l_set;
    next_addr = l_addr;
    next_sh = sh;
    next_word = word;
    next_tmr = tmr - 16'h0001;
    next_slot = slot;
    next_pc = pc;
    next_low = low;
    next_ack = l_ack;
    case (l_state)
      mcl_pkg::LS_IDLE:
      begin
        next_tmr = tmr;
        if (req_ev)
        begin
          // only the address decode picks lines and kind
          next_addr = held.addr;
          next_sh = held.data;
          next_op = mcl_pkg::mcl_decode_op(held.addr);
          next_set = mcl_pkg::mcl_decode_set(held.addr);
          next_tmr = 16'(mcl_pkg::CLK_HIGH_CYC - 1);
          if (mcl_pkg::mcl_decode_op(held.addr) == mcl_pkg::OP_NONE)
            next_state = mcl_pkg::LS_DONE;
          else
            next_state = mcl_pkg::LS_SETUP;
        end
      end
      mcl_pkg::LS_SETUP:
      begin
        // sub-address settles one high time before any clock or strobe
        if (tmr_end)
        begin
          next_slot = 5'h00;
          next_pc = 4'h0;
          if (l_op == mcl_pkg::OP_CMD)
          begin
            next_state = mcl_pkg::LS_CMD_SHIFT;
            next_low = 1'b1;
            next_tmr = 16'(mcl_pkg::CLK_LOW_CYC - 1);
          end
          else if (l_op == mcl_pkg::OP_MON)
          begin
            next_state = mcl_pkg::LS_MON_STROBE;
            next_tmr = 16'(mcl_pkg::MON_STB_CYC - 1);
          end
          else
          begin
            next_state = mcl_pkg::LS_ANA_HOLD;
            next_tmr = 16'(ANA_HOLD_CYC - 1);
          end
        end
      end
      mcl_pkg::LS_CMD_SHIFT:
      begin
        if (tmr_end && low)
        begin
          next_low = 1'b0;
          next_tmr = 16'(mcl_pkg::CLK_HIGH_CYC - 1);
        end
        else if (tmr_end && slot == 5'(mcl_pkg::DATA_W - 1))
        begin
          next_state = mcl_pkg::LS_CMD_STROBE;
          next_tmr = 16'(mcl_pkg::CMD_STB_CYC - 1);
        end
        else if (tmr_end)
        begin
          // next bit leaves with the leading edge of its pulse
          next_low = 1'b1;
          next_tmr = 16'(mcl_pkg::CLK_LOW_CYC - 1);
          next_slot = slot + 5'h01;
          next_sh = {sh[mcl_pkg::DATA_W-2:0], 1'b0};
        end
      end
      mcl_pkg::LS_CMD_STROBE:
      begin
        if (tmr_end)
          next_state = mcl_pkg::LS_DONE;
      end
      mcl_pkg::LS_MON_STROBE:
      begin
        // high gap lets the strobe end and the first bit settle
        if (tmr_end)
        begin
          next_state = mcl_pkg::LS_MON_SHIFT;
          next_low = 1'b0;
          next_tmr = 16'(mcl_pkg::CLK_HIGH_CYC - 1);
        end
      end
      mcl_pkg::LS_MON_SHIFT:
      begin
        if (tmr_end && !low)
        begin
          next_low = 1'b1;
          next_tmr = 16'(mcl_pkg::CLK_LOW_CYC - 1);
          // sample at the leading edge; line is low true
          if (!pause)
            next_word = {word[mcl_pkg::DATA_W-2:0], ~mon_bit};
        end
        else if (tmr_end && slot == 5'(mcl_pkg::MON_SLOTS - 1))
          next_state = mcl_pkg::LS_DONE;
        else if (tmr_end)
        begin
          next_low = 1'b0;
          next_tmr = 16'(mcl_pkg::CLK_HIGH_CYC - 1);
          next_slot = slot + 5'h01;
          next_pc = pause ? 4'h0 : pc + 4'h1;
        end
      end
      mcl_pkg::LS_ANA_HOLD:
      begin
        if (tmr_end)
          next_state = mcl_pkg::LS_DONE;
      end
      mcl_pkg::LS_DONE:
      begin
        next_ack = ~l_ack;
        next_state = mcl_pkg::LS_IDLE;
      end
      default:
        next_state = mcl_pkg::LS_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge link_clk)
  begin
    if (!lk_rst_b)
    begin
      l_state <= mcl_pkg::LS_IDLE;
      l_op <= mcl_pkg::OP_NONE;
      l_set <= '0;
      l_addr <= '0;
      sh <= '0;
      word <= '0;
      tmr <= 16'h0000;
      slot <= 5'h00;
      pc <= 4'h0;
      low <= 1'b0;
      l_ack <= 1'b0;
    end
    else
    begin
      l_state <= next_state;
      l_op <= next_op;
      l_set <= next_set;
      l_addr <= next_addr;
      sh <= next_sh;
      word <= next_word;
      tmr <= next_tmr;
      slot <= next_slot;
      pc <= next_pc;
      low <= next_low;
      l_ack <= next_ack;
    end
  end

  // line activity before per-set steering; pauses give no pulse
  assign cmd_clk_on = (l_state == mcl_pkg::LS_CMD_SHIFT) && low;
  assign mon_clk_on = (l_state == mcl_pkg::LS_MON_SHIFT) && low && !pause;
  assign cmd_stb_on = l_state == mcl_pkg::LS_CMD_STROBE;
  assign mon_stb_on = l_state == mcl_pkg::LS_MON_STROBE;
  assign cmd_line_on = (l_op == mcl_pkg::OP_CMD) &&
                       (l_state == mcl_pkg::LS_SETUP ||
                        l_state == mcl_pkg::LS_CMD_SHIFT);
  assign ana_on = (l_op == mcl_pkg::OP_ANA) &&
                  (l_state == mcl_pkg::LS_SETUP ||
                   l_state == mcl_pkg::LS_ANA_HOLD);

  // sub-address: lower nibble, inverted; registered so pins never glitch
  always_ff @(posedge link_clk)
  begin
    if (!lk_rst_b)
      sub_addr_n <= 4'hF;
    else
      sub_addr_n <= ~l_addr[mcl_pkg::SUB_W-1:0];
  end

  // command line sets, steered by the decoded set index
  for (genvar i = 0; i < mcl_pkg::CMD_SETS; i++)
  begin : g_cmd
    always_ff @(posedge link_clk)
    begin
      if (!lk_rst_b)
      begin
        command_serial_line_n[i] <= 1'b1;
        command_shift_clock_n[i] <= 1'b1;
        command_latch_strobe_n[i] <= 1'b1;
      end
      else
      begin
        command_serial_line_n[i] <= ~(cmd_line_on && l_set == 3'(i) &&
                                      sh[mcl_pkg::DATA_W-1]);
        command_shift_clock_n[i] <= ~(cmd_clk_on && l_set == 3'(i));
        command_latch_strobe_n[i] <= ~(cmd_stb_on && l_set == 3'(i));
      end
    end
  end

  // monitor line sets
  for (genvar i = 0; i < mcl_pkg::MON_SETS; i++)
  begin : g_mon
    always_ff @(posedge link_clk)
    begin
      if (!lk_rst_b)
      begin
        monitor_load_strobe_n[i] <= 1'b1;
        monitor_shift_clock_n[i] <= 1'b1;
      end
      else
      begin
        monitor_load_strobe_n[i] <= ~(mon_stb_on && l_set == 3'(i));
        monitor_shift_clock_n[i] <= ~(mon_clk_on && l_set == 3'(i));
      end
    end
  end

  // analog controller selects
  for (genvar i = 0; i < mcl_pkg::ANA_CTRLS; i++)
  begin : g_ana
    always_ff @(posedge link_clk)
    begin
      if (!lk_rst_b)
        analog_sel_n[i] <= 1'b1;
      else
        analog_sel_n[i] <= ~(ana_on && l_set == 3'(i));
    end
  end

  // helper: count clock pulses of the current operation
  logic prev_clk_low;
  logic [4:0] pulse_cnt;
  wire logic any_clk_low;
  assign any_clk_low = !(&command_shift_clock_n) || !(&monitor_shift_clock_n);
  always_ff @(posedge link_clk)
  begin
    if (!lk_rst_b || l_state == mcl_pkg::LS_IDLE)
    begin
      prev_clk_low <= 1'b0;
      pulse_cnt <= 5'h00;
    end
    else
    begin
      prev_clk_low <= any_clk_low;
      if (any_clk_low && !prev_clk_low)
        pulse_cnt <= pulse_cnt + 5'h01;
    end
  end

  chk_pulse_count_24: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    (l_state == mcl_pkg::LS_DONE && l_op != mcl_pkg::OP_NONE &&
     l_op != mcl_pkg::OP_ANA) |-> pulse_cnt == 5'h18)
    else $error("operation did not give exactly 24 clock pulses");

  chk_sub_addr_match: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    (l_state != mcl_pkg::LS_IDLE && $past(l_state) != mcl_pkg::LS_IDLE)
    |-> sub_addr_n == ~l_addr[3:0])
    else $error("sub-address not the inverted lower nibble");

  chk_one_line_active: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    $countones({~command_shift_clock_n, ~command_latch_strobe_n,
                ~monitor_load_strobe_n, ~monitor_shift_clock_n}) <= 1)
    else $error("more than one clock or strobe line active");

  chk_cmd_data_stable: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    (!(&command_shift_clock_n) && $past(!(&command_shift_clock_n)))
    |-> $stable(command_serial_line_n))
    else $error("command data moved while its clock was low");

  chk_pause_no_pulse: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    (l_state == mcl_pkg::LS_MON_SHIFT && pause)
    |=> (&monitor_shift_clock_n))
    else $error("monitor clock pulsed in a pause slot");

  chk_idle_lines_high: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    (l_state == mcl_pkg::LS_IDLE && $past(l_state) == mcl_pkg::LS_IDLE)
    |-> (&{command_shift_clock_n, command_latch_strobe_n,
           monitor_load_strobe_n, monitor_shift_clock_n, analog_sel_n}))
    else $error("controller line active while idle");

  chk_strobe_then_shift: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    $rose(&monitor_load_strobe_n) |-> l_state == mcl_pkg::LS_MON_SHIFT ##1
    (&monitor_shift_clock_n) [*8])
    else $error("monitor shift did not follow strobe with a gap");

  chk_cmd_group_decode: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    !(&command_latch_strobe_n) |-> (l_addr[7:4] >= mcl_pkg::CMD_GRP_BASE)
    ##1 (!(&command_latch_strobe_n) || l_state == mcl_pkg::LS_DONE ||
         l_state == mcl_pkg::LS_IDLE))
    else $error("command strobe outside a command group");

  chk_analog_decode: assert property (
    @(posedge link_clk) disable iff (!lk_rst_b)
    !(&analog_sel_n) |-> (l_op == mcl_pkg::OP_ANA && !l_addr[7]))
    else $error("analog select without an analog address");

  chk_busy_blocks: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    accept |=> !req_ready [*2])
    else $error("second request taken while one is in flight");
endmodule
`default_nettype wire

// file: verification/mcl_ctrl_model.sv
// behavioural daisy-chain controller: command latch and monitor unload
`timescale 1ns/100ps
`default_nettype none
module mcl_ctrl_model #(
  parameter logic [3:0] MY_SUB = 4'h0,
  parameter logic [23:0] PAT = 24'h000000
) (
  input wire logic [3:0] sub_addr_n,
  input wire logic cmd_dat_n,
  input wire logic cmd_clk_n,
  input wire logic cmd_stb_n,
  input wire logic mon_stb_n,
  input wire logic mon_clk_n,
  output logic mon_pull_low,
  output logic [23:0] cmd_hold
);
  logic [23:0] cmd_sr = 24'h000000;
  logic [23:0] mon_sr = 24'h000000;
  wire logic sel;
  // low-true sub-address compare gates every action below
  assign sel = (sub_addr_n == ~MY_SUB);
  initial cmd_hold = 24'h000000;
  // trailing edge of a low-true pulse is its rising edge
  always @(posedge cmd_clk_n)
    if (sel)
      cmd_sr <= {cmd_sr[22:0], ~cmd_dat_n};
  // whole word moves to static storage only on the strobe
  always @(negedge cmd_stb_n)
    if (sel)
      cmd_hold <= cmd_sr;
  always @(negedge mon_stb_n)
    if (sel)
      mon_sr <= PAT;
  always @(posedge mon_clk_n)
    if (sel)
      mon_sr <= {mon_sr[22:0], 1'b0};
  // open collector: pulls low or lets the pull-up win, never drives high
  assign mon_pull_low = sel & mon_sr[23];
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the link sequencer with four controller models
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] data;
    logic [23:0] exp;
    mcl_pkg::mcl_op_e kind;
  } mcl_row_s;
  function automatic logic [23:0] pat(input int g);
    return 24'h3C5A96 + 24'(g) * 24'h10F0E1;
  endfunction
  localparam int NROWS = 9;
  localparam int LIMIT = 85000;
  // kind is written by hand per row, never taken from the decode
  localparam mcl_row_s ROWS [NROWS] = '{
    '{8'hC2, 24'h800001, 24'h800001, mcl_pkg::OP_CMD},
    '{8'hD3, 24'h5A3C96, 24'h5A3C96, mcl_pkg::OP_CMD},
    '{8'hE4, 24'hFFFFFE, 24'hFFFFFE, mcl_pkg::OP_CMD},
    '{8'h82, 24'h000000, pat(0), mcl_pkg::OP_MON},
    '{8'hB5, 24'h000000, pat(3), mcl_pkg::OP_MON},
    '{8'h87, 24'h000000, 24'h000000, mcl_pkg::OP_MON},
    '{8'h05, 24'h000000, 24'h000001, mcl_pkg::OP_ANA},
    '{8'h7A, 24'h000000, 24'h000080, mcl_pkg::OP_ANA},
    '{8'hF0, 24'h000000, 24'h000000, mcl_pkg::OP_NONE}
  };
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic mon_ready = 1'b0;
  mcl_pkg::mcl_req_s req = '0;
  mcl_pkg::mcl_mon_s mon;
  logic req_ready, done, done_bad, mon_valid, bad;
  logic [3:0] sub_addr_n, mon_stb_n, mon_clk_n;
  wire logic [3:0] pull_low;
  logic [2:0] cmd_dat_n, cmd_clk_n, cmd_stb_n;
  logic [7:0] ana_sel_n;
  logic [7:0] ana_seen = 8'h00;
  wire logic [23:0] hold [4];
  logic [31:0] expq [$];
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  wire logic [3:0] mon_line_n;
  wire logic [3:0] cd_n, cc_n, cs_n;
  wire logic [16:0] idle;
  // pull-up on each party line: a released line reads high
  assign mon_line_n = ~pull_low;
  assign cd_n = {1'b1, cmd_dat_n};
  assign cc_n = {1'b1, cmd_clk_n};
  assign cs_n = {1'b1, cmd_stb_n};
  assign idle = {cmd_dat_n, cmd_clk_n, cmd_stb_n, mon_stb_n, mon_clk_n};
  always #12.5 ref_clk = ~ref_clk;
  // link clock offset so its edges never line up with the system clock
  initial
  begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  mcl_link #(.ANA_HOLD_CYC(50)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .link_clk(link_clk),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .done(done), .done_bad(done_bad), .mon_valid(mon_valid),
    .mon_ready(mon_ready), .mon(mon), .sub_addr_n(sub_addr_n),
    .command_serial_line_n(cmd_dat_n), .command_shift_clock_n(cmd_clk_n),
    .command_latch_strobe_n(cmd_stb_n), .monitor_load_strobe_n(mon_stb_n),
    .monitor_shift_clock_n(mon_clk_n), .monitor_serial_line_n(mon_line_n),
    .analog_sel_n(ana_sel_n)
  );
  for (genvar g = 0; g < 4; g++)
  begin : g_ctrl
    mcl_ctrl_model #(.MY_SUB(4'(g + 2)), .PAT(pat(g))) i_ctrl (
      .sub_addr_n(sub_addr_n), .cmd_dat_n(cd_n[g]), .cmd_clk_n(cc_n[g]),
      .cmd_stb_n(cs_n[g]), .mon_stb_n(mon_stb_n[g]),
      .mon_clk_n(mon_clk_n[g]), .mon_pull_low(pull_low[g]),
      .cmd_hold(hold[g])
    );
  end
  // sticky record of analog selects since the last accepted request
  always @(posedge ref_clk)
    ana_seen <= (req_valid && req_ready) ? 8'h00 : ana_seen | ~ana_sel_n;
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    cmp_word({31'h0, got}, {31'h0, exp}, what);
  endtask
  // hold the request until an edge samples ready high
  task automatic send(input logic [7:0] a, input logic [23:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{addr: a, data: d};
    do @(posedge ref_clk);
    while (req_ready !== 1'b1 && ++n < 200);
    req_valid <= 1'b0;
  endtask
  task automatic run_op(input logic [7:0] a, input logic [23:0] d);
    int n;
    n = 0;
    send(a, d);
    do @(posedge ref_clk);
    while (done !== 1'b1 && ++n < 20000);
    cmp_flag(done, 1'b1, "operation never completed");
    cmp_flag(req_ready, 1'b1, "ready not back with done");
    bad = done_bad;
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge ref_clk);
    for (int i = 0; i < NROWS; i++)
    begin
      run_op(ROWS[i].addr, ROWS[i].data);
      cmp_flag(bad, ROWS[i].kind == mcl_pkg::OP_NONE, "unmapped flag");
      cmp_word({24'h0, ana_seen}, ROWS[i].kind == mcl_pkg::OP_ANA ?
               ROWS[i].exp : 32'h0, "analog select");
      cmp_word({15'h0, idle}, 32'h0001FFFF, "lines not idle high");
      cmp_word({28'h0, sub_addr_n}, {28'h0, ~ROWS[i].addr[3:0]},
               "sub address");
      if (ROWS[i].kind == mcl_pkg::OP_CMD)
        cmp_word({8'h0, hold[ROWS[i].addr[5:4]]}, {8'h0, ROWS[i].exp},
                 "command latched");
      if (ROWS[i].kind == mcl_pkg::OP_MON)
        expq.push_back({ROWS[i].addr, ROWS[i].exp});
    end
    // results stayed queued while the consumer stalled; drain in order
    while (expq.size() > 0)
    begin
      cmp_flag(mon_valid, 1'b1, "monitor result missing");
      cmp_word(mon, expq.pop_front(), "monitor word");
      mon_ready <= 1'b1;
      @(posedge ref_clk);
      mon_ready <= 1'b0;
      @(posedge ref_clk);
    end
    cmp_flag(mon_valid, 1'b0, "buffer not empty");
    // reset in mid-shift: no strobe, so the old command must survive
    send(8'hC2, 24'h0F0F0F);
    repeat (3000) @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (10) @(posedge ref_clk);
    cmp_flag(done, 1'b0, "done in reset");
    cmp_flag(mon_valid, 1'b0, "result in reset");
    cmp_word({28'h0, sub_addr_n}, 32'h0000000F, "sub address in reset");
    cmp_word({15'h0, idle}, 32'h0001FFFF, "lines in reset");
    cmp_word({8'h0, hold[0]}, 32'h00800001, "partial command kept");
    rst_b <= 1'b1;
    repeat (10) @(posedge ref_clk);
    run_op(8'hF7, 24'h000000);
    cmp_flag(bad, 1'b1, "recovery after reset");
    summarize();
  end
endmodule
`default_nettype wire
